// [core/vmor_regs.sv]
// Purpose: operational register bank of the vision module
// Assumes: word-indexed register port, reads answer one cycle later
// Notes:   display outputs are raw segment patterns, A..G in bits 6..0
//
// Behaviour
// - firmware version read-only, major/minor decimal bytes
// - application id four ASCII chars, two registers
// - control bit 15 resets the module
// - control bit 14 enters sleep
// - control bit 13 gives engine ownership
// - control bit 12 gives LED ownership
// - control bit 11 locks push buttons
// - control bit 7 reports learn/run switch
// - bus address in bits 7:1, 0x70-0x7E
// - segment register drives raw segments both displays
// - character register maps ASCII onto displays
// - decimal register takes 0-99 per display, shows its units digit
// - integrate category over ms time, max 2000
// - trained count read-only 16-bit
// - four label registers, plain storage
// - revision register low byte decimal
// - speed enum 1=1200, 2=4800
// - enums 3-7 up to 115200, default 115200
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
module vmor_regs
	import vmor_pkg::*;
#(
	parameter logic [15:0] FW_VERSION  = 16'h0100,
	parameter logic [15:0] APP_ID_HIGH = 16'h4142,
	parameter logic [15:0] APP_ID_LOW  = 16'h4344,
	parameter logic [15:0] FW_REVISION = 16'h0000
) (
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	input  wire logic [9:0]  i_addr,
	input  wire logic [15:0] i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	input  wire logic        i_learn_switch,
	input  wire logic [15:0] i_trained_count,
	input  wire logic [7:0]  i_category,
	input  wire logic [6:0]  i_module_left_seg,
	input  wire logic [6:0]  i_module_right_seg,
	input  wire logic [7:0]  i_buttons,
	output logic      [15:0] o_rdata,
	output logic             o_module_reset,
	output logic             o_sleep,
	output logic             o_engine_host_owned,
	output logic             o_led_host_owned,
	output logic      [7:0]  o_buttons,
	output logic      [6:0]  o_bus_address,
	output logic      [6:0]  o_left_seg,
	output logic      [6:0]  o_right_seg,
	output logic      [7:0]  o_category,
	output logic      [2:0]  o_serial_speed
);

	typedef struct packed {
		logic [1:0]    sw_sync;
		logic [15:0]   rdata;
		vmor_mode_type mode;
		logic [2:0]    rst_cnt;
		logic          engine_own;
		logic          led_own;
		logic          btn_lock;
		logic [7:0]    buttons;
		logic [6:0]    bus_addr;
		logic [6:0]    host_left;
		logic [6:0]    host_right;
		logic [6:0]    left;
		logic [6:0]    right;
		logic [15:0]   int_ms;
		logic [16:0]   tick_cnt;
		logic [15:0]   ms_cnt;
		logic [7:0]    cat_hold;
		logic [7:0]    cat;
		logic [15:0]   label0;
		logic [15:0]   label1;
		logic [15:0]   label2;
		logic [15:0]   label3;
		logic [2:0]    speed;
	} vmor_state_type;

	vmor_state_type st_r;
	vmor_state_type st_nxt;

	// limited ASCII to segments (A..G = bits 6..0), blank otherwise
	function automatic logic [6:0] vmor_ascii_seg(input logic [7:0] c);
		case (c)
			8'h30, 8'h4F: vmor_ascii_seg = 7'h7E;
			8'h31: vmor_ascii_seg = 7'h30;
			8'h32: vmor_ascii_seg = 7'h6D;
			8'h33: vmor_ascii_seg = 7'h79;
			8'h34: vmor_ascii_seg = 7'h33;
			8'h35, 8'h53: vmor_ascii_seg = 7'h5B;
			8'h36: vmor_ascii_seg = 7'h5F;
			8'h37: vmor_ascii_seg = 7'h70;
			8'h38: vmor_ascii_seg = 7'h7F;
			8'h39: vmor_ascii_seg = 7'h7B;
			8'h41: vmor_ascii_seg = 7'h77;
			8'h43: vmor_ascii_seg = 7'h4E;
			8'h45: vmor_ascii_seg = 7'h4F;
			8'h46: vmor_ascii_seg = 7'h47;
			8'h48: vmor_ascii_seg = 7'h37;
			8'h4C: vmor_ascii_seg = 7'h0E;
			8'h50: vmor_ascii_seg = 7'h67;
			8'h55: vmor_ascii_seg = 7'h3E;
			8'h2D: vmor_ascii_seg = 7'h01;
			default: vmor_ascii_seg = 7'h00;
		endcase
	endfunction : vmor_ascii_seg

	// a byte 0-99 shown as its units digit; out of range shows a dash (segment G)
	function automatic logic [6:0] vmor_dec_seg(input logic [7:0] v);
		logic [7:0] d;
		d = v % 8'h0A;
		if (v > VMOR_DEC_MAX) begin
			vmor_dec_seg = 7'h01;
		end else begin
			vmor_dec_seg = vmor_ascii_seg(8'h30 + d);
		end
	endfunction : vmor_dec_seg

	logic wr_ctl;

	always_comb begin
		st_nxt = st_r;
		wr_ctl = i_wr && (i_addr == VMOR_OFS_CONTROL);
		st_nxt.sw_sync = {st_r.sw_sync[0], i_learn_switch};
		st_nxt.rdata = 16'h0000;
		if (i_rd) begin
			case (i_addr)
				VMOR_OFS_FW_VERSION:  st_nxt.rdata = FW_VERSION;
				VMOR_OFS_APP_ID_HIGH: st_nxt.rdata = APP_ID_HIGH;
				VMOR_OFS_APP_ID_LOW:  st_nxt.rdata = APP_ID_LOW;
				VMOR_OFS_CONTROL: begin
					st_nxt.rdata[VMOR_BIT_SLEEP]      = (st_r.mode == VMOR_SLEEP);
					st_nxt.rdata[VMOR_BIT_ENGINE_OWN] = st_r.engine_own;
					st_nxt.rdata[VMOR_BIT_LED_OWN]    = st_r.led_own;
					st_nxt.rdata[VMOR_BIT_BTN_LOCK]   = st_r.btn_lock;
					st_nxt.rdata[VMOR_BIT_LEARN_SW]   = st_r.sw_sync[1];
				end
				VMOR_OFS_BUS_ADDR:    st_nxt.rdata = {8'h00, st_r.bus_addr, 1'b0};
				VMOR_OFS_INTEGRATION: st_nxt.rdata = st_r.int_ms;
				VMOR_OFS_TRAINED:     st_nxt.rdata = i_trained_count;
				VMOR_OFS_LABEL0:      st_nxt.rdata = st_r.label0;
				VMOR_OFS_LABEL1:      st_nxt.rdata = st_r.label1;
				VMOR_OFS_LABEL2:      st_nxt.rdata = st_r.label2;
				VMOR_OFS_LABEL3:      st_nxt.rdata = st_r.label3;
				VMOR_OFS_FW_REVISION: st_nxt.rdata = {8'h00, FW_REVISION[7:0]};
				VMOR_OFS_SPEED:       st_nxt.rdata = {13'h0000, st_r.speed};
				default:              st_nxt.rdata = 16'h0000;
			endcase
		end
		// mode machine: reset pulse, sleep until cleared
		case (st_r.mode)
			VMOR_RUN: begin
				if (wr_ctl && i_wdata[VMOR_BIT_RESET]) begin
					st_nxt.mode = VMOR_RESET;
				end else if (wr_ctl && i_wdata[VMOR_BIT_SLEEP]) begin
					st_nxt.mode = VMOR_SLEEP;
				end
			end
			VMOR_SLEEP: begin
				if (wr_ctl && i_wdata[VMOR_BIT_RESET]) begin
					st_nxt.mode = VMOR_RESET;
				end else if (wr_ctl && !i_wdata[VMOR_BIT_SLEEP]) begin
					st_nxt.mode = VMOR_RUN;
				end
			end
			VMOR_RESET: begin
				if (st_r.rst_cnt == 3'(VMOR_RESET_PULSE_CYCLES - 1)) begin
					st_nxt.mode = VMOR_RUN;
				end
			end
			default: st_nxt.mode = VMOR_RUN;
		endcase
		st_nxt.rst_cnt = (st_r.mode == VMOR_RESET) ? st_r.rst_cnt + 3'h1 : 3'h0;
		if (wr_ctl) begin
			st_nxt.engine_own = i_wdata[VMOR_BIT_ENGINE_OWN];
			st_nxt.led_own    = i_wdata[VMOR_BIT_LED_OWN];
			st_nxt.btn_lock   = i_wdata[VMOR_BIT_BTN_LOCK];
		end
		st_nxt.buttons = st_r.btn_lock ? 8'h00 : i_buttons;
		if (i_wr && i_addr == VMOR_OFS_BUS_ADDR && i_wdata[7:1] >= VMOR_ADDR_MIN
				&& i_wdata[7:1] <= VMOR_ADDR_MAX) begin
			st_nxt.bus_addr = i_wdata[7:1];
		end
		if (i_wr && st_r.led_own) begin
			case (i_addr)
				VMOR_OFS_SEGMENTS: begin
					st_nxt.host_left  = i_wdata[14:8];
					st_nxt.host_right = i_wdata[6:0];
				end
				VMOR_OFS_CHARACTERS: begin
					st_nxt.host_left  = vmor_ascii_seg(i_wdata[15:8]);
					st_nxt.host_right = vmor_ascii_seg(i_wdata[7:0]);
				end
				VMOR_OFS_DECIMAL: begin
					st_nxt.host_left  = vmor_dec_seg(i_wdata[15:8]);
					st_nxt.host_right = vmor_dec_seg(i_wdata[7:0]);
				end
				default: st_nxt.host_right = st_r.host_right;
			endcase
		end
		st_nxt.left  = st_r.led_own ? st_r.host_left : i_module_left_seg;
		st_nxt.right = st_r.led_own ? st_r.host_right : i_module_right_seg;
		if (i_wr && i_addr == VMOR_OFS_INTEGRATION) begin
			st_nxt.int_ms = (i_wdata > VMOR_INT_MAX_MS) ? VMOR_INT_MAX_MS : i_wdata;
		end
		// category must hold steady for int_ms rollovers of the free-running ms tick, so the first ms can be short
		st_nxt.tick_cnt = (st_r.tick_cnt == 17'(VMOR_MS_CYCLES - 1)) ? 17'h00000 : st_r.tick_cnt + 17'h00001;
		if (i_category != st_r.cat_hold) begin
			st_nxt.cat_hold = i_category;
			st_nxt.ms_cnt   = 16'h0000;
		end else if (st_r.ms_cnt >= st_r.int_ms) begin
			st_nxt.cat = st_r.cat_hold;
		end else if (st_r.tick_cnt == 17'(VMOR_MS_CYCLES - 1)) begin
			st_nxt.ms_cnt = st_r.ms_cnt + 16'h0001;
		end
		if (i_wr) begin
			case (i_addr)
				VMOR_OFS_LABEL0: st_nxt.label0 = i_wdata;
				VMOR_OFS_LABEL1: st_nxt.label1 = i_wdata;
				VMOR_OFS_LABEL2: st_nxt.label2 = i_wdata;
				VMOR_OFS_LABEL3: st_nxt.label3 = i_wdata;
				VMOR_OFS_SPEED: begin
					if (i_wdata[15:3] == 13'h0000 && i_wdata[2:0] != 3'h0) begin
						st_nxt.speed = i_wdata[2:0];
					end
				end
				default: st_nxt.speed = st_nxt.speed;
			endcase
		end
		if (st_r.mode == VMOR_RESET) begin
			st_nxt.engine_own = 1'b0;
			st_nxt.led_own    = 1'b0;
			st_nxt.btn_lock   = 1'b0;
			st_nxt.bus_addr   = VMOR_ADDR_RST;
			st_nxt.int_ms     = VMOR_INT_RST;
			st_nxt.speed      = VMOR_SPEED_115200;
			st_nxt.host_left  = 7'h00;
			st_nxt.host_right = 7'h00;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			st_r          <= '0;
			st_r.mode     <= VMOR_RUN;
			st_r.bus_addr <= VMOR_ADDR_RST;
			st_r.int_ms   <= VMOR_INT_RST;
			st_r.speed    <= VMOR_SPEED_115200;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign o_rdata             = st_r.rdata;
	assign o_module_reset      = st_r.mode[2];
	assign o_sleep             = st_r.mode[1];
	assign o_engine_host_owned = st_r.engine_own;
	assign o_led_host_owned    = st_r.led_own;
	assign o_buttons           = st_r.buttons;
	assign o_bus_address       = st_r.bus_addr;
	assign o_left_seg          = st_r.left;
	assign o_right_seg         = st_r.right;
	assign o_category          = st_r.cat;
	assign o_serial_speed      = st_r.speed;

	a_fw_read: assert property (@(posedge i_clk) disable iff (i_rst)
		i_rd && i_addr == VMOR_OFS_FW_VERSION |=> o_rdata == FW_VERSION)
		else $error("firmware version read wrong");
	a_reset_pulse: assert property (@(posedge i_clk) disable iff (i_rst)
		!o_module_reset && wr_ctl && i_wdata[VMOR_BIT_RESET] |=> o_module_reset [*4] ##1 !o_module_reset)
		else $error("module reset pulse wrong");
	a_sleep_enter: assert property (@(posedge i_clk) disable iff (i_rst)
		st_r.mode == VMOR_RUN && wr_ctl && !i_wdata[VMOR_BIT_RESET] && i_wdata[VMOR_BIT_SLEEP] |=> o_sleep)
		else $error("sleep not entered");
	a_engine_own: assert property (@(posedge i_clk) disable iff (i_rst)
		wr_ctl && !o_module_reset |=> o_engine_host_owned == $past(i_wdata[VMOR_BIT_ENGINE_OWN]))
		else $error("engine ownership wrong");
	a_btn_lock: assert property (@(posedge i_clk) disable iff (i_rst)
		st_r.btn_lock |=> o_buttons == 8'h00)
		else $error("buttons not locked");
	a_addr_range: assert property (@(posedge i_clk) disable iff (i_rst)
		o_bus_address >= VMOR_ADDR_MIN && o_bus_address <= VMOR_ADDR_MAX)
		else $error("bus address out of range");
	a_seg_host: assert property (@(posedge i_clk) disable iff (i_rst)
		i_wr && i_addr == VMOR_OFS_SEGMENTS && st_r.led_own && !o_module_reset
		##1 st_r.led_own |=> o_left_seg == $past(i_wdata[14:8], 2))
		else $error("segment write not shown");
	a_int_max: assert property (@(posedge i_clk) disable iff (i_rst)
		st_r.int_ms <= VMOR_INT_MAX_MS)
		else $error("integration time above limit");
	a_speed_valid: assert property (@(posedge i_clk) disable iff (i_rst)
		o_serial_speed != 3'h0)
		else $error("serial speed invalid");
	a_display_gate: assert property (@(posedge i_clk) disable iff (i_rst)
		!st_r.led_own |=> o_left_seg == $past(i_module_left_seg))
		else $error("display not under module");
	a_app_high: assert property (@(posedge i_clk) disable iff (i_rst)
		i_rd && i_addr == VMOR_OFS_APP_ID_HIGH |=> o_rdata == APP_ID_HIGH)
		else $error("application id high read wrong");
	a_app_low: assert property (@(posedge i_clk) disable iff (i_rst)
		i_rd && i_addr == VMOR_OFS_APP_ID_LOW |=> o_rdata == APP_ID_LOW)
		else $error("application id low read wrong");
	a_rev_read: assert property (@(posedge i_clk) disable iff (i_rst)
		i_rd && i_addr == VMOR_OFS_FW_REVISION |=> o_rdata == {8'h00, FW_REVISION[7:0]})
		else $error("firmware revision read wrong");
	a_trained_read: assert property (@(posedge i_clk) disable iff (i_rst)
		i_rd && i_addr == VMOR_OFS_TRAINED |=> o_rdata == $past(i_trained_count))
		else $error("trained count read wrong");
	a_rdata_idle: assert property (@(posedge i_clk) disable iff (i_rst)
		!i_rd |=> o_rdata == 16'h0000)
		else $error("read data not idle");
	a_ctl_undef: assert property (@(posedge i_clk) disable iff (i_rst)
		i_rd && i_addr == VMOR_OFS_CONTROL
		|=> o_rdata[15] == 1'b0 && o_rdata[10:8] == 3'h0 && o_rdata[6:0] == 7'h00)
		else $error("undefined control bits not zero");
	a_learn_read: assert property (@(posedge i_clk) disable iff (i_rst)
		i_rd && i_addr == VMOR_OFS_CONTROL |=> o_rdata[VMOR_BIT_LEARN_SW] == $past(i_learn_switch, 3))
		else $error("learn switch status wrong");
	a_sleep_exit: assert property (@(posedge i_clk) disable iff (i_rst)
		o_sleep && wr_ctl && !i_wdata[VMOR_BIT_RESET] && !i_wdata[VMOR_BIT_SLEEP] |=> !o_sleep)
		else $error("sleep not left");
	a_sleep_read: assert property (@(posedge i_clk) disable iff (i_rst)
		i_rd && i_addr == VMOR_OFS_CONTROL |=> o_rdata[VMOR_BIT_SLEEP] == $past(o_sleep))
		else $error("sleep status wrong");
	a_ctl_owners: assert property (@(posedge i_clk) disable iff (i_rst)
		i_rd && i_addr == VMOR_OFS_CONTROL
		|=> o_rdata[13:11] == {$past(o_engine_host_owned), $past(o_led_host_owned), $past(st_r.btn_lock)})
		else $error("ownership status wrong");
	a_led_own: assert property (@(posedge i_clk) disable iff (i_rst)
		wr_ctl && !o_module_reset |=> o_led_host_owned == $past(i_wdata[VMOR_BIT_LED_OWN]))
		else $error("led ownership wrong");
	a_lock_bit: assert property (@(posedge i_clk) disable iff (i_rst)
		wr_ctl && !o_module_reset |=> st_r.btn_lock == $past(i_wdata[VMOR_BIT_BTN_LOCK]))
		else $error("button lock bit wrong");
	a_btn_pass: assert property (@(posedge i_clk) disable iff (i_rst)
		!st_r.btn_lock |=> o_buttons == $past(i_buttons))
		else $error("buttons not passed");
	a_addr_write: assert property (@(posedge i_clk) disable iff (i_rst)
		i_wr && i_addr == VMOR_OFS_BUS_ADDR && !o_module_reset && i_wdata[7:1] >= VMOR_ADDR_MIN
		&& i_wdata[7:1] <= VMOR_ADDR_MAX |=> o_bus_address == $past(i_wdata[7:1]))
		else $error("bus address write lost");
	a_soft_clear: assert property (@(posedge i_clk) disable iff (i_rst)
		o_module_reset |=> !o_engine_host_owned && !o_led_host_owned && !st_r.btn_lock
		&& o_bus_address == VMOR_ADDR_RST && o_serial_speed == VMOR_SPEED_115200)
		else $error("soft reset left configuration");
	a_label_write: assert property (@(posedge i_clk) disable iff (i_rst)
		i_wr && i_addr == VMOR_OFS_LABEL0 |=> st_r.label0 == $past(i_wdata))
		else $error("label write lost");
	a_speed_write: assert property (@(posedge i_clk) disable iff (i_rst)
		i_wr && i_addr == VMOR_OFS_SPEED && !o_module_reset
		&& i_wdata[15:3] == 13'h0000 && i_wdata[2:0] != 3'h0 |=> o_serial_speed == $past(i_wdata[2:0]))
		else $error("serial speed write lost");
	a_speed_read: assert property (@(posedge i_clk) disable iff (i_rst)
		i_rd && i_addr == VMOR_OFS_SPEED |=> o_rdata == {13'h0000, $past(o_serial_speed)})
		else $error("serial speed read wrong");
	a_int_write: assert property (@(posedge i_clk) disable iff (i_rst)
		i_wr && i_addr == VMOR_OFS_INTEGRATION && !o_module_reset
		&& i_wdata <= VMOR_INT_MAX_MS |=> st_r.int_ms == $past(i_wdata))
		else $error("integration write lost");
	a_right_gate: assert property (@(posedge i_clk) disable iff (i_rst)
		!st_r.led_own |=> o_right_seg == $past(i_module_right_seg))
		else $error("right display not under module");
	a_cat_hold: assert property (@(posedge i_clk) disable iff (i_rst)
		$changed(i_category) |=> o_category == $past(o_category))
		else $error("category passed without integration");

endmodule : vmor_regs
`default_nettype wire

// [core/vmor_pkg.sv]
// Purpose: constants for the operational register bank
// Assumes: 16-bit registers on word-indexed addresses
// Notes:   identity defaults are arbitrary
package vmor_pkg;
	localparam int VMOR_AW = 10;
	localparam logic [9:0] VMOR_OFS_FW_VERSION   = 10'h200;
	localparam logic [9:0] VMOR_OFS_APP_ID_HIGH  = 10'h201;
	localparam logic [9:0] VMOR_OFS_APP_ID_LOW   = 10'h202;
	localparam logic [9:0] VMOR_OFS_CONTROL      = 10'h203;
	localparam logic [9:0] VMOR_OFS_BUS_ADDR     = 10'h204;
	localparam logic [9:0] VMOR_OFS_SEGMENTS     = 10'h205;
	localparam logic [9:0] VMOR_OFS_CHARACTERS   = 10'h206;
	localparam logic [9:0] VMOR_OFS_DECIMAL      = 10'h207;
	localparam logic [9:0] VMOR_OFS_INTEGRATION  = 10'h208;
	localparam logic [9:0] VMOR_OFS_TRAINED      = 10'h209;
	localparam logic [9:0] VMOR_OFS_LABEL0       = 10'h20A;
	localparam logic [9:0] VMOR_OFS_LABEL1       = 10'h20B;
	localparam logic [9:0] VMOR_OFS_LABEL2       = 10'h20C;
	localparam logic [9:0] VMOR_OFS_LABEL3       = 10'h20D;
	localparam logic [9:0] VMOR_OFS_FW_REVISION  = 10'h20E;
	localparam logic [9:0] VMOR_OFS_SPEED        = 10'h20F;
	localparam int VMOR_BIT_RESET      = 15;
	localparam int VMOR_BIT_SLEEP      = 14;
	localparam int VMOR_BIT_ENGINE_OWN = 13;
	localparam int VMOR_BIT_LED_OWN    = 12;
	localparam int VMOR_BIT_BTN_LOCK   = 11;
	localparam int VMOR_BIT_LEARN_SW   = 7;
	localparam logic [6:0]  VMOR_ADDR_MIN   = 7'h70;
	localparam logic [6:0]  VMOR_ADDR_MAX   = 7'h7E;
	localparam logic [6:0]  VMOR_ADDR_RST   = 7'h70;
	localparam logic [7:0]  VMOR_DEC_MAX    = 8'h63;
	localparam logic [15:0] VMOR_INT_MAX_MS = 16'h07D0;
	localparam logic [15:0] VMOR_INT_RST    = 16'h0000;
	localparam logic [2:0]  VMOR_SPEED_1200   = 3'h1;
	localparam logic [2:0]  VMOR_SPEED_4800   = 3'h2;
	localparam logic [2:0]  VMOR_SPEED_9600   = 3'h3;
	localparam logic [2:0]  VMOR_SPEED_19200  = 3'h4;
	localparam logic [2:0]  VMOR_SPEED_38400  = 3'h5;
	localparam logic [2:0]  VMOR_SPEED_57600  = 3'h6;
	localparam logic [2:0]  VMOR_SPEED_115200 = 3'h7;
	localparam int VMOR_CLK_HZ = 100000000;
	localparam int VMOR_MS_CYCLES = VMOR_CLK_HZ / 1000;
	localparam int VMOR_RESET_PULSE_CYCLES = 4;
	typedef enum logic [2:0] {
		VMOR_RUN   = 3'b001,
		VMOR_SLEEP = 3'b010,
		VMOR_RESET = 3'b100
	} vmor_mode_type;
endpackage : vmor_pkg

// [tb/vmor_host.sv]
// Purpose: host model driving the register port
// Assumes: one strobe a cycle, read data only in the cycle after the read
// Notes:   signals change by nonblocking assignment just after a rising edge
`timescale 1ns/10ps
`default_nettype none
module vmor_host (
	input  wire logic        i_clk,
	input  wire logic [15:0] i_rdata,
	output logic      [9:0]  o_addr,
	output logic      [15:0] o_wdata,
	output logic             o_wr,
	output logic             o_rd
);
	initial begin
		o_addr  = 10'h000;
		o_wdata = 16'h0000;
		o_wr    = 1'b0;
		o_rd    = 1'b0;
	end

	task automatic wr(input logic [9:0] a, input logic [15:0] d);
		@(posedge i_clk);
		o_addr  <= a;
		o_wdata <= d;
		o_wr    <= 1'b1;
		@(posedge i_clk);
		o_wr    <= 1'b0;
		o_wdata <= ~d;
	endtask : wr

	task automatic rd(input logic [9:0] a, output logic [15:0] d);
		@(posedge i_clk);
		o_addr <= a;
		o_rd   <= 1'b1;
		@(posedge i_clk);
		o_rd   <= 1'b0;
		#1 d = i_rdata;
	endtask : rd
endmodule : vmor_host
`default_nettype wire

// [tb/vmor_regs_tb.sv]
// Purpose: self-checking bench for the operational register bank
// Assumes: host model issues all register traffic
// Notes:   identity values are arbitrary
`timescale 1ns/10ps
`default_nettype none
module vmor_regs_tb;
	import vmor_pkg::*;
	localparam logic [15:0] FW_V = 16'h0203;
	localparam logic [15:0] AP_H = 16'h5859;
	localparam logic [15:0] AP_L = 16'h5A31;
	localparam logic [15:0] FW_R = 16'h0004;
	logic        clk;
	logic        rst;
	logic        learn;
	logic [9:0]  addr;
	logic [15:0] wdata;
	logic        wr;
	logic        rd;
	logic [15:0] rdata;
	logic        mrst;
	logic        slp;
	logic        eng;
	logic        led;
	logic [7:0]  btn;
	logic [6:0]  badr;
	logic [6:0]  lseg;
	logic [6:0]  rseg;
	logic [2:0]  spd;
	logic [7:0]  cat;
	logic [7:0]  cat_out;
	logic [15:0] d;
	int          error_cnt;
	int          check_count;
	int          cyc;

	vmor_regs #(.FW_VERSION(FW_V), .APP_ID_HIGH(AP_H), .APP_ID_LOW(AP_L), .FW_REVISION(FW_R)) u_vmor_regs (
		.i_clk(clk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
		.i_learn_switch(learn), .i_trained_count(16'h0123), .i_category(cat),
		.i_module_left_seg(7'h11), .i_module_right_seg(7'h22), .i_buttons(8'hA5),
		.o_rdata(rdata), .o_module_reset(mrst), .o_sleep(slp), .o_engine_host_owned(eng),
		.o_led_host_owned(led), .o_buttons(btn), .o_bus_address(badr), .o_left_seg(lseg),
		.o_right_seg(rseg), .o_category(cat_out), .o_serial_speed(spd));
	vmor_host u_vmor_host (.i_clk(clk), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic print_verdict();
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : print_verdict

	task automatic t_ident();
		u_vmor_host.wr(VMOR_OFS_FW_VERSION, 16'hFFFF);
		u_vmor_host.rd(VMOR_OFS_FW_VERSION, d);
		chk("fw_version", d, FW_V);
		@(posedge clk);
		#1 chk("rdata_idle", rdata, 16'h0000);
		u_vmor_host.rd(VMOR_OFS_APP_ID_HIGH, d);
		chk("app_high", d, AP_H);
		u_vmor_host.rd(VMOR_OFS_APP_ID_LOW, d);
		chk("app_low", d, AP_L);
		u_vmor_host.rd(VMOR_OFS_FW_REVISION, d);
		chk("fw_rev", d, FW_R);
		u_vmor_host.wr(VMOR_OFS_TRAINED, 16'h7777);
		u_vmor_host.rd(VMOR_OFS_TRAINED, d);
		chk("trained", d, 16'h0123);
	endtask : t_ident

	task automatic t_cat();
		chk("cat_zero_ms", {8'h00, cat_out}, 16'h0005);
		@(posedge clk);
		cat <= 8'h09;
		repeat (3) @(posedge clk);
		#1 chk("cat_follow", {8'h00, cat_out}, 16'h0009);
		u_vmor_host.wr(VMOR_OFS_INTEGRATION, 16'h0001);
		cat <= 8'h0C;
		repeat (10) @(posedge clk);
		#1 chk("cat_hold", {8'h00, cat_out}, 16'h0009);
	endtask : t_cat

	task automatic t_ctl();
		u_vmor_host.wr(VMOR_OFS_CONTROL, 16'h7F7F);
		u_vmor_host.rd(VMOR_OFS_CONTROL, d);
		chk("control", d, 16'h7880);
		chk("outs", {12'h000, slp, eng, led, mrst}, 16'h000E);
		chk("btn_lock", {8'h00, btn}, 16'h0000);
		u_vmor_host.wr(VMOR_OFS_CONTROL, 16'h0000);
		@(posedge clk);
		#1 chk("outs_off", {12'h000, slp, eng, led, mrst}, 16'h0000);
		chk("btn_open", {8'h00, btn}, 16'h00A5);
		@(posedge clk);
		learn <= 1'b0;
		repeat (2) @(posedge clk);
		u_vmor_host.rd(VMOR_OFS_CONTROL, d);
		chk("learn_run", d, 16'h0000);
		@(posedge clk);
		learn <= 1'b1;
	endtask : t_ctl

	task automatic t_disp();
		u_vmor_host.wr(VMOR_OFS_SEGMENTS, 16'h5A33);
		@(posedge clk);
		#1 chk("seg_module", {2'b00, lseg, rseg}, {2'b00, 7'h11, 7'h22});
		u_vmor_host.wr(VMOR_OFS_CONTROL, 16'h1000);
		u_vmor_host.wr(VMOR_OFS_SEGMENTS, 16'h5A33);
		@(posedge clk);
		#1 chk("seg_host", {2'b00, lseg, rseg}, {2'b00, 7'h5A, 7'h33});
		u_vmor_host.rd(VMOR_OFS_SEGMENTS, d);
		chk("seg_wo", d, 16'h0000);
		u_vmor_host.wr(VMOR_OFS_CHARACTERS, 16'h4131);
		@(posedge clk);
		#1 chk("char_host", {2'b00, lseg, rseg}, {2'b00, 7'h77, 7'h30});
		u_vmor_host.wr(VMOR_OFS_DECIMAL, 16'h0309);
		@(posedge clk);
		#1 chk("dec_host", {2'b00, lseg, rseg}, {2'b00, 7'h79, 7'h7B});
	endtask : t_disp

	task automatic t_cfg();
		u_vmor_host.wr(VMOR_OFS_BUS_ADDR, 16'h00E4);
		u_vmor_host.wr(VMOR_OFS_BUS_ADDR, 16'h00FE);
		u_vmor_host.rd(VMOR_OFS_BUS_ADDR, d);
		chk("bus_addr", {9'h000, badr}, 16'h0072);
		chk("bus_addr_rd", d, 16'h00E4);
		u_vmor_host.wr(VMOR_OFS_INTEGRATION, 16'h07D1);
		u_vmor_host.rd(VMOR_OFS_INTEGRATION, d);
		chk("integ", d, 16'h07D0);
		for (int i = 0; i < 4; i++) begin
			u_vmor_host.wr(VMOR_OFS_LABEL0 + 10'(i), 16'hC0DE + 16'(i));
		end
		for (int i = 0; i < 4; i++) begin
			u_vmor_host.rd(VMOR_OFS_LABEL0 + 10'(i), d);
			chk("label", d, 16'hC0DE + 16'(i));
		end
		chk("speed_rst", {13'h0000, spd}, 16'h0007);
		for (int i = 1; i < 8; i++) begin
			u_vmor_host.wr(VMOR_OFS_SPEED, 16'(i));
			u_vmor_host.rd(VMOR_OFS_SPEED, d);
			chk("speed", {13'h0000, spd}, 16'(i));
			chk("speed_rd", d, 16'(i));
		end
		u_vmor_host.wr(VMOR_OFS_SPEED, 16'h0000);
		u_vmor_host.rd(VMOR_OFS_SPEED, d);
		chk("speed_zero", d, 16'h0007);
	endtask : t_cfg

	task automatic t_soft();
		int n;
		n = 0;
		u_vmor_host.wr(VMOR_OFS_SPEED, 16'h0002);
		u_vmor_host.wr(VMOR_OFS_CONTROL, 16'h9000);
		repeat (8) begin
			#1 if (mrst === 1'b1) n++;
			@(posedge clk);
		end
		chk("reset_len", 16'(n), 16'(VMOR_RESET_PULSE_CYCLES));
		u_vmor_host.rd(VMOR_OFS_CONTROL, d);
		chk("ctl_after", d, 16'h0080);
		chk("addr_after", {9'h000, badr}, 16'h0070);
		chk("speed_after", {13'h0000, spd}, 16'h0007);
		u_vmor_host.rd(VMOR_OFS_LABEL3, d);
		chk("label_kept", d, 16'hC0E1);
	endtask : t_soft

	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			error_cnt++;
			print_verdict();
		end
	end

	initial begin
		rst = 1'b1;
		learn = 1'b1;
		cat = 8'h05;
		error_cnt = 0;
		check_count = 0;
		cyc = 0;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		t_ident();
		t_cat();
		t_ctl();
		t_disp();
		t_cfg();
		t_soft();
		print_verdict();
	end
endmodule : vmor_regs_tb
`default_nettype wire
